// File: core/motor_algo_tuning_regs.v
/*
 * Algorithm tuning register pair with decoded parameter outputs and
 * the speed input deglitch filter that one field steers.
 * Assumes a single 100 MHz clock, synchronous reset and a plain
 * register port with read data one cycle after the read strobe.
 */
// The plain strobed port was chosen for this implementation.
`timescale 1ns/1ps
`include "algo_tuning_defs.vh"
module motor_algo_tuning_regs (
    input wire clk,
    input wire rst,
    input wire [`ADDR_W-1:0] addr,
    input wire [31:0] wdata,
    input wire wr_stb,
    input wire rd_stb,
    output reg [31:0] rdata,
    input wire speed_pin,
    input wire speed_pulse_mode,
    output wire speed_pin_filt,
    output reg [1:0] brake_exit_code,
    output reg [6:0] brake_exit_tenth_pct,
    output reg [1:0] glitch_code,
    output reg [6:0] glitch_cycles,
    output reg quick_startup_detect_enable,
    output reg [1:0] stop_declare_persistence,
    output reg [6:0] stop_persist_ms,
    output reg [1:0] run_declare_persistence,
    output reg [6:0] run_persist_ms,
    output reg [1:0] startup_detect_timeout,
    output reg [10:0] timeout_ms,
    output reg [2:0] handoff_min_back_emf,
    output reg [11:0] handoff_bemf_mv,
    output reg [2:0] estimation_current_target,
    output reg [6:0] est_current_pct,
    output reg [1:0] estimation_speed_target,
    output reg [5:0] est_speed_pct,
    output reg [2:0] estimation_accel_rate,
    output reg [7:0] est_accel_tenth_hz,
    output reg [2:0] reverse_decel_ratio,
    output reg [7:0] reverse_decel_pct,
    output reg [9:0] field_weaken_prop_gain,
    output reg [17:0] prop_gain_e4,
    output reg [9:0] field_weaken_integ_gain,
    output reg [17:0] integ_gain_e2,
    output reg field_weaken_enable
);

////////////////////////////////////////////////////////////////////////
// decode tables

function [6:0] brake_exit_lut;
    input [1:0] code;
    begin
        case (code)
            2'h0: brake_exit_lut = 7'h19;
            2'h1: brake_exit_lut = 7'h32;
            2'h2: brake_exit_lut = 7'h4b;
            default: brake_exit_lut = 7'h64;
        endcase
    end
endfunction

// hold counts cut to the output width on purpose; all fit in 7 bits
localparam [31:0] glitch_cyc_1 = `CYC_CEIL(`GLITCH_T1_NS);
localparam [31:0] glitch_cyc_2 = `CYC_CEIL(`GLITCH_T2_NS);
localparam [31:0] glitch_cyc_3 = `CYC_CEIL(`GLITCH_T3_NS);

function [6:0] glitch_lut;
    input [1:0] code;
    begin
        case (code)
            2'h0: glitch_lut = 7'h00;
            2'h1: glitch_lut = glitch_cyc_1[6:0];
            2'h2: glitch_lut = glitch_cyc_2[6:0];
            default: glitch_lut = glitch_cyc_3[6:0];
        endcase
    end
endfunction

// stop and run persistence share one table
function [6:0] persist_lut;
    input [1:0] code;
    begin
        case (code)
            2'h0: persist_lut = 7'h01;
            2'h1: persist_lut = 7'h05;
            2'h2: persist_lut = 7'h32;
            default: persist_lut = 7'h64;
        endcase
    end
endfunction

function [10:0] timeout_lut;
    input [1:0] code;
    begin
        case (code)
            2'h0: timeout_lut = 11'h1f4;
            2'h1: timeout_lut = 11'h2ee;
            2'h2: timeout_lut = 11'h3e8;
            default: timeout_lut = 11'h7d0;
        endcase
    end
endfunction

function [11:0] bemf_lut;
    input [2:0] code;
    begin
        case (code)
            3'h0: bemf_lut = 12'h000;
            3'h1: bemf_lut = 12'h064;
            3'h2: bemf_lut = 12'h0c8;
            3'h3: bemf_lut = 12'h1f4;
            3'h4: bemf_lut = 12'h3e8;
            3'h5: bemf_lut = 12'h7d0;
            3'h6: bemf_lut = 12'h9c4;
            default: bemf_lut = 12'hbb8;
        endcase
    end
endfunction

function [5:0] speed_lut;
    input [1:0] code;
    begin
        case (code)
            2'h0: speed_lut = 6'h0f;
            2'h1: speed_lut = 6'h19;
            2'h2: speed_lut = 6'h23;
            default: speed_lut = 6'h32;
        endcase
    end
endfunction

// acceleration in steps of 0.1 Hz/s
function [7:0] accel_lut;
    input [2:0] code;
    begin
        case (code)
            3'h0: accel_lut = 8'h01;
            3'h1: accel_lut = 8'h05;
            3'h2: accel_lut = 8'h0a;
            3'h3: accel_lut = 8'h14;
            3'h4: accel_lut = 8'h1e;
            3'h5: accel_lut = 8'h32;
            3'h6: accel_lut = 8'h64;
            default: accel_lut = 8'hc8;
        endcase
    end
endfunction

function [7:0] decel_lut;
    input [2:0] code;
    begin
        case (code)
            3'h0: decel_lut = 8'h32;
            3'h1: decel_lut = 8'h3c;
            3'h2: decel_lut = 8'h46;
            3'h3: decel_lut = 8'h50;
            3'h4: decel_lut = 8'h5a;
            3'h5: decel_lut = 8'h64;
            3'h6: decel_lut = 8'h7d;
            default: decel_lut = 8'h96;
        endcase
    end
endfunction

// mantissa times 1000 over ten to the exponent; this one form serves
// both gains, proportional in 1e-4 units and integral in 1e-2 units
function [17:0] gain_lut;
    input [9:0] field;
    reg [17:0] mant;
    begin
        mant = {10'h000, field[7:0]};
        case (field[9:8])
            2'h0: gain_lut = mant * 18'h003e8;
            2'h1: gain_lut = mant * 18'h00064;
            2'h2: gain_lut = mant * 18'h0000a;
            default: gain_lut = mant;
        endcase
    end
endfunction

////////////////////////////////////////////////////////////////////////
// register storage and bus

reg [31:0] tuning_one_r;
reg [31:0] tuning_two_r;
reg [31:0] rd_nxt;
wire hit_one;
wire hit_two;

assign hit_one = (addr == `OFS_TUNING_ONE);
assign hit_two = (addr == `OFS_TUNING_TWO);

// reserved bits never take write data, so they stay zero
always @(posedge clk) begin
    if (rst) begin
        tuning_one_r <= `RST_TUNING_ONE;
        tuning_two_r <= `RST_TUNING_TWO;
    end else if (wr_stb) begin
        if (hit_one) begin
            tuning_one_r <= wdata & `MASK_TUNING_ONE;
        end
        if (hit_two) begin
            tuning_two_r <= wdata & `MASK_TUNING_TWO;
        end
    end
end

// unlisted offsets read zero and swallow writes
always @* begin
    rd_nxt = 32'h00000000;
    if (hit_one) begin
        rd_nxt = tuning_one_r & `MASK_TUNING_ONE;
    end else if (hit_two) begin
        rd_nxt = tuning_two_r & `MASK_TUNING_TWO;
    end
end

// data stand only in the cycle after the strobe
always @(posedge clk) begin
    if (rst) begin
        rdata <= 32'h00000000;
    end else if (rd_stb) begin
        rdata <= rd_nxt;
    end else begin
        rdata <= 32'h00000000;
    end
end

////////////////////////////////////////////////////////////////////////
// field extraction

wire [1:0] brake_f = tuning_one_r[`F_BRAKE_EXIT_MSB:`F_BRAKE_EXIT_LSB];
wire [1:0] glitch_f = tuning_one_r[`F_GLITCH_MSB:`F_GLITCH_LSB];
wire quick_f = tuning_one_r[`F_QUICK_DET];
wire [1:0] stop_f = tuning_one_r[`F_STOP_MSB:`F_STOP_LSB];
wire [1:0] run_f = tuning_one_r[`F_RUN_MSB:`F_RUN_LSB];
wire [1:0] tout_f = tuning_one_r[`F_TIMEOUT_MSB:`F_TIMEOUT_LSB];
wire [2:0] bemf_f = tuning_one_r[`F_BEMF_MSB:`F_BEMF_LSB];
wire [2:0] curr_f = tuning_one_r[`F_CURR_MSB:`F_CURR_LSB];
wire [1:0] speed_f = tuning_one_r[`F_SPEED_MSB:`F_SPEED_LSB];
wire [2:0] accel_f = tuning_one_r[`F_ACCEL_MSB:`F_ACCEL_LSB];
wire [2:0] decel_f = tuning_one_r[`F_DECEL_MSB:`F_DECEL_LSB];
wire [9:0] kp_f = tuning_two_r[`F_KP_MSB:`F_KP_LSB];
wire [9:0] ki_f = tuning_two_r[`F_KI_MSB:`F_KI_LSB];
wire fw_f = tuning_two_r[`F_FW_EN];

////////////////////////////////////////////////////////////////////////
// registered parameter outputs, one cycle behind the registers

always @(posedge clk) begin
    if (rst) begin
        brake_exit_code <= 2'h0;
        brake_exit_tenth_pct <= 7'h00;
        glitch_code <= 2'h0;
        glitch_cycles <= 7'h00;
        quick_startup_detect_enable <= 1'b0;
        stop_declare_persistence <= 2'h0;
        stop_persist_ms <= 7'h00;
        run_declare_persistence <= 2'h0;
        run_persist_ms <= 7'h00;
        startup_detect_timeout <= 2'h0;
        timeout_ms <= 11'h000;
        handoff_min_back_emf <= 3'h0;
        handoff_bemf_mv <= 12'h000;
        estimation_current_target <= 3'h0;
        est_current_pct <= 7'h00;
        estimation_speed_target <= 2'h0;
        est_speed_pct <= 6'h00;
        estimation_accel_rate <= 3'h0;
        est_accel_tenth_hz <= 8'h00;
        reverse_decel_ratio <= 3'h0;
        reverse_decel_pct <= 8'h00;
        field_weaken_prop_gain <= 10'h000;
        prop_gain_e4 <= 18'h00000;
        field_weaken_integ_gain <= 10'h000;
        integ_gain_e2 <= 18'h00000;
        field_weaken_enable <= 1'b0;
    end else begin
        brake_exit_code <= brake_f;
        brake_exit_tenth_pct <= brake_exit_lut(brake_f);
        glitch_code <= glitch_f;
        glitch_cycles <= glitch_lut(glitch_f);
        quick_startup_detect_enable <= quick_f;
        stop_declare_persistence <= stop_f;
        stop_persist_ms <= persist_lut(stop_f);
        run_declare_persistence <= run_f;
        run_persist_ms <= persist_lut(run_f);
        startup_detect_timeout <= tout_f;
        timeout_ms <= timeout_lut(tout_f);
        handoff_min_back_emf <= bemf_f;
        handoff_bemf_mv <= bemf_lut(bemf_f);
        estimation_current_target <= curr_f;
        est_current_pct <= {4'h0, curr_f} * 7'h0a + 7'h0a;
        estimation_speed_target <= speed_f;
        est_speed_pct <= speed_lut(speed_f);
        estimation_accel_rate <= accel_f;
        est_accel_tenth_hz <= accel_lut(accel_f);
        reverse_decel_ratio <= decel_f;
        reverse_decel_pct <= decel_lut(decel_f);
        field_weaken_prop_gain <= kp_f;
        prop_gain_e4 <= gain_lut(kp_f);
        field_weaken_integ_gain <= ki_f;
        integ_gain_e2 <= gain_lut(ki_f);
        field_weaken_enable <= fw_f;
    end
end

////////////////////////////////////////////////////////////////////////
// speed input deglitch, only in pulse-width or frequency input mode

reg filt_bypass_r;

always @(posedge clk) begin
    if (rst) begin
        filt_bypass_r <= 1'b1;
    end else begin
        filt_bypass_r <= (glitch_f == 2'h0) | ~speed_pulse_mode;
    end
end

speed_glitch_filter #(
    .CNT_W(7)
) u_speed_filter (
    .clk(clk),
    .rst(rst),
    .pin_in(speed_pin),
    .bypass(filt_bypass_r),
    .hold_cycles(glitch_cycles),
    .pin_out(speed_pin_filt)
);

endmodule

// File: core/algo_tuning_defs.vh
/*
 * Constants for the algorithm tuning register pair: offsets, field
 * positions, write masks, reset values and filter timing.
 * Assumes a 100 MHz clock and an 8-bit register address.
 */
// How it works
// - bits 30-29: brake exit speed delta
// - bits 28-27: speed input glitch filter
// - bit 26: quick initial speed detection
// - bits 25-24: stop declare persistence time
// - bits 23-22: run declare persistence time
// - bits 21-20: initial speed detection timeout
// - bits 19-17: least back-emf for handoff
// - bits 10-8: estimation current target
// - bits 7-6: estimation speed target
// - bits 5-3: estimation acceleration rate
// - bits 2-0: reverse deceleration ratio
// - second register 30-21: weakening proportional gain
// - second register 20-11: weakening integral gain
// - second register bit 10: weakening enable
// - first register at a0, resets zero
// - second register at a2, resets zero
`ifndef ALGO_TUNING_DEFS_VH
`define ALGO_TUNING_DEFS_VH

`define ADDR_W 8
`define OFS_TUNING_ONE 8'ha0
`define OFS_TUNING_TWO 8'ha2
`define RST_TUNING_ONE 32'h00000000
`define RST_TUNING_TWO 32'h00000000
`define MASK_TUNING_ONE 32'h7ffe07ff
`define MASK_TUNING_TWO 32'h7ffffc00

`define F_BRAKE_EXIT_MSB 30
`define F_BRAKE_EXIT_LSB 29
`define F_GLITCH_MSB 28
`define F_GLITCH_LSB 27
`define F_QUICK_DET 26
`define F_STOP_MSB 25
`define F_STOP_LSB 24
`define F_RUN_MSB 23
`define F_RUN_LSB 22
`define F_TIMEOUT_MSB 21
`define F_TIMEOUT_LSB 20
`define F_BEMF_MSB 19
`define F_BEMF_LSB 17
`define F_CURR_MSB 10
`define F_CURR_LSB 8
`define F_SPEED_MSB 7
`define F_SPEED_LSB 6
`define F_ACCEL_MSB 5
`define F_ACCEL_LSB 3
`define F_DECEL_MSB 2
`define F_DECEL_LSB 0
`define F_KP_MSB 30
`define F_KP_LSB 21
`define F_KI_MSB 20
`define F_KI_LSB 11
`define F_FW_EN 10

`define CLK_PERIOD_NS 10
`define GLITCH_T1_NS 200
`define GLITCH_T2_NS 500
`define GLITCH_T3_NS 1000
`define CYC_CEIL(ns) (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// File: core/speed_glitch_filter.v
/*
 * Deglitch filter for the speed/wake input pin.
 * Assumes the pin is asynchronous; it is synchronised here first.
 */
`timescale 1ns/1ps
module speed_glitch_filter #(
    parameter CNT_W = 7
) (
    input wire clk,
    input wire rst,
    input wire pin_in,
    input wire bypass,
    input wire [CNT_W-1:0] hold_cycles,
    output reg pin_out
);

reg sync1_r;
reg sync2_r;
reg [CNT_W-1:0] cnt_r;

always @(posedge clk) begin
    if (rst) begin
        sync1_r <= 1'b0;
        sync2_r <= 1'b0;
    end else begin
        sync1_r <= pin_in;
        sync2_r <= sync1_r;
    end
end

////////////////////////////////////////////////////////////////////////
// a new level must stand hold_cycles before it is passed on
always @(posedge clk) begin
    if (rst) begin
        cnt_r <= {CNT_W{1'b0}};
        pin_out <= 1'b0;
    end else if (bypass) begin
        cnt_r <= {CNT_W{1'b0}};
        pin_out <= sync2_r;
    end else if (sync2_r == pin_out) begin
        cnt_r <= {CNT_W{1'b0}};
    end else if (cnt_r + {{(CNT_W-1){1'b0}}, 1'b1} >= hold_cycles) begin
        cnt_r <= {CNT_W{1'b0}};
        pin_out <= sync2_r;
    end else begin
        cnt_r <= cnt_r + {{(CNT_W-1){1'b0}}, 1'b1};
    end
end

endmodule

// File: test/algo_tuning_monitor.sv
/* Checker for the tuning register pair: read path, field placement
   and the decoded parameter tables.
   Assumes it is bound into motor_algo_tuning_regs with one clock. */
`timescale 1ns/1ps
`include "algo_tuning_defs.vh"
module algo_tuning_monitor (
    input wire clk,
    input wire rst,
    input wire [`ADDR_W-1:0] addr,
    input wire [31:0] wdata,
    input wire wr_stb,
    input wire rd_stb,
    input wire [31:0] rdata,
    input wire [1:0] brake_exit_code,
    input wire [6:0] brake_exit_tenth_pct,
    input wire [1:0] glitch_code,
    input wire [6:0] glitch_cycles,
    input wire quick_startup_detect_enable,
    input wire [1:0] stop_declare_persistence,
    input wire [6:0] stop_persist_ms,
    input wire [1:0] run_declare_persistence,
    input wire [6:0] run_persist_ms,
    input wire [1:0] startup_detect_timeout,
    input wire [10:0] timeout_ms,
    input wire [2:0] handoff_min_back_emf,
    input wire [11:0] handoff_bemf_mv,
    input wire [2:0] estimation_current_target,
    input wire [6:0] est_current_pct,
    input wire [1:0] estimation_speed_target,
    input wire [5:0] est_speed_pct,
    input wire [2:0] estimation_accel_rate,
    input wire [7:0] est_accel_tenth_hz,
    input wire [2:0] reverse_decel_ratio,
    input wire [7:0] reverse_decel_pct,
    input wire [9:0] field_weaken_prop_gain,
    input wire [17:0] prop_gain_e4,
    input wire [9:0] field_weaken_integ_gain,
    input wire [17:0] integ_gain_e2,
    input wire field_weaken_enable
);
    localparam logic [6:0] persist_tab [4] = '{7'h01, 7'h05, 7'h32, 7'h64};
    localparam logic [6:0] glitch_tab [4] = '{7'h00, 7'h14, 7'h32, 7'h64};
    localparam logic [10:0] tmo_tab [4] = '{11'h1f4, 11'h2ee, 11'h3e8,
        11'h7d0};
    localparam logic [11:0] bemf_tab [8] = '{12'h000, 12'h064, 12'h0c8,
        12'h1f4, 12'h3e8, 12'h7d0, 12'h9c4, 12'hbb8};
    localparam logic [5:0] spd_tab [4] = '{6'h0f, 6'h19, 6'h23, 6'h32};
    localparam logic [7:0] acc_tab [8] = '{8'h01, 8'h05, 8'h0a, 8'h14,
        8'h1e, 8'h32, 8'h64, 8'hc8};
    localparam logic [7:0] dec_tab [8] = '{8'h32, 8'h3c, 8'h46, 8'h50,
        8'h5a, 8'h64, 8'h7d, 8'h96};
    localparam logic [17:0] div_tab [4] = '{18'h00001, 18'h0000a,
        18'h00064, 18'h003e8};
    // stored words rebuilt from the raw field outputs
    wire [31:0] one_view = {1'b0, brake_exit_code, glitch_code,
        quick_startup_detect_enable, stop_declare_persistence,
        run_declare_persistence, startup_detect_timeout,
        handoff_min_back_emf, 6'h00, estimation_current_target,
        estimation_speed_target, estimation_accel_rate, reverse_decel_ratio};
    wire [31:0] two_view = {1'b0, field_weaken_prop_gain,
        field_weaken_integ_gain, field_weaken_enable, 10'h000};

    // exact: divisor always divides mantissa times 1000
    function automatic [17:0] gain(input [9:0] f);
        gain = ({10'h000, f[7:0]} * 18'h003e8) / div_tab[f[9:8]];
    endfunction

    default clocking @(posedge clk); endclocking
    default disable iff (rst);
////////////////////////////////////////////////////////////
    AST_RD_IDLE: assert property (
        $past(rd_stb) == 1'b0 |-> rdata == 32'h00000000)
        else $error("read data not zero outside a read");
    AST_RD_ONE: assert property (
        rd_stb && addr == `OFS_TUNING_ONE |=> rdata == one_view)
        else $error("first register read mismatch");
    AST_RD_TWO: assert property (
        rd_stb && addr == `OFS_TUNING_TWO |=> rdata == two_view)
        else $error("second register read mismatch");
    AST_RD_UNMAPPED: assert property (
        rd_stb && addr != `OFS_TUNING_ONE && addr != `OFS_TUNING_TWO
        |=> rdata == 32'h00000000) else $error("unmapped read not zero");
    AST_WR_ONE: assert property (
        wr_stb && addr == `OFS_TUNING_ONE |-> ##2
        one_view == ($past(wdata, 2) & 32'h7ffe07ff))
        else $error("first register write not stored");
    AST_WR_TWO: assert property (
        wr_stb && addr == `OFS_TUNING_TWO |-> ##2
        two_view == ($past(wdata, 2) & 32'h7ffffc00))
        else $error("second register write not stored");
    AST_BRAKE: assert property (
        !$past(rst) |-> brake_exit_tenth_pct ==
        7'h19 * ({5'h00, brake_exit_code} + 7'h01))
        else $error("brake exit decode wrong");
    AST_GLITCH: assert property (
        !$past(rst) |-> glitch_cycles == glitch_tab[glitch_code])
        else $error("glitch hold decode wrong");
    AST_PERSIST: assert property (
        !$past(rst) |-> stop_persist_ms == persist_tab[stop_declare_persistence]
        && run_persist_ms == persist_tab[run_declare_persistence])
        else $error("persistence decode wrong");
    AST_TIMEOUT: assert property (
        !$past(rst) |-> timeout_ms == tmo_tab[startup_detect_timeout])
        else $error("timeout decode wrong");
    AST_BEMF: assert property (
        !$past(rst) |-> handoff_bemf_mv == bemf_tab[handoff_min_back_emf])
        else $error("back emf decode wrong");
    AST_EST: assert property (
        !$past(rst) |-> est_current_pct == 7'h0a *
        ({4'h0, estimation_current_target} + 7'h01)
        && est_speed_pct == spd_tab[estimation_speed_target]
        && est_accel_tenth_hz == acc_tab[estimation_accel_rate])
        else $error("estimation decode wrong");
    AST_DECEL: assert property (
        !$past(rst) |-> reverse_decel_pct == dec_tab[reverse_decel_ratio])
        else $error("decel ratio decode wrong");
    AST_GAINS: assert property (
        !$past(rst) |-> prop_gain_e4 == gain(field_weaken_prop_gain)
        && integ_gain_e2 == gain(field_weaken_integ_gain))
        else $error("gain decode wrong");
endmodule

bind motor_algo_tuning_regs algo_tuning_monitor algo_tuning_monitor_i (
    .clk, .rst, .addr, .wdata, .wr_stb, .rd_stb, .rdata, .brake_exit_code,
    .brake_exit_tenth_pct, .glitch_code, .glitch_cycles,
    .quick_startup_detect_enable, .stop_declare_persistence,
    .stop_persist_ms, .run_declare_persistence, .run_persist_ms,
    .startup_detect_timeout, .timeout_ms, .handoff_min_back_emf,
    .handoff_bemf_mv, .estimation_current_target, .est_current_pct,
    .estimation_speed_target, .est_speed_pct, .estimation_accel_rate,
    .est_accel_tenth_hz, .reverse_decel_ratio, .reverse_decel_pct,
    .field_weaken_prop_gain, .prop_gain_e4, .field_weaken_integ_gain,
    .integ_gain_e2, .field_weaken_enable);

// File: test/motor_algo_tuning_regs_test.sv
/* Self-checking bench: reset values, reserved bits, every field code except for the 10-bit gains,
   mid-run reset and the speed pin deglitch filter.
   Assumes algo_tuning_monitor is compiled alongside and bound in. */
`timescale 1ns/1ps
`include "algo_tuning_defs.vh"
module motor_algo_tuning_regs_test;
    reg clk = 1'b0;
    reg rst = 1'b1;
    reg [`ADDR_W-1:0] addr = 8'h00;
    reg [31:0] wdata = 32'h00000000;
    reg wr_stb = 1'b0;
    reg rd_stb = 1'b0;
    reg speed_pin = 1'b0;
    reg speed_pulse_mode = 1'b0;
    wire [31:0] rdata;
    wire speed_pin_filt;
    wire field_weaken_enable;
    integer failures = 0;
    integer n_compared = 0;
    integer hi_cnt = 0;
    integer i;
    reg [2:0] c;
    reg [31:0] d1;
    reg [31:0] d2;

    always #5 clk = ~clk;
    always @(posedge clk) if (speed_pin_filt === 1'b1) hi_cnt <= hi_cnt + 1;

    motor_algo_tuning_regs motor_algo_tuning_regs_i (.clk, .rst, .addr,
        .wdata, .wr_stb, .rd_stb, .rdata, .speed_pin, .speed_pulse_mode,
        .speed_pin_filt, .brake_exit_code(), .brake_exit_tenth_pct(),
        .glitch_code(), .glitch_cycles(), .quick_startup_detect_enable(),
        .stop_declare_persistence(), .stop_persist_ms(),
        .run_declare_persistence(), .run_persist_ms(),
        .startup_detect_timeout(), .timeout_ms(), .handoff_min_back_emf(),
        .handoff_bemf_mv(), .estimation_current_target(),
        .est_current_pct(), .estimation_speed_target(), .est_speed_pct(),
        .estimation_accel_rate(), .est_accel_tenth_hz(),
        .reverse_decel_ratio(), .reverse_decel_pct(),
        .field_weaken_prop_gain(), .prop_gain_e4(),
        .field_weaken_integ_gain(), .integ_gain_e2(), .field_weaken_enable);
////////////////////////////////////////////////////////////
    task chk(input [31:0] got, input [31:0] exp);
        begin
            n_compared = n_compared + 1;
            if (got !== exp) begin
                failures = failures + 1;
                $display("ERROR %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask

    // callers write mapped offsets only; others stay untouched
    task wr(input [7:0] a, input [31:0] d);
        begin
            @(posedge clk);
            addr <= a;
            wdata <= d;
            wr_stb <= 1'b1;
            @(posedge clk);
            wr_stb <= 1'b0;
        end
    endtask

    // data stands only in the cycle after the strobe
    task rd_chk(input [7:0] a, input [31:0] exp);
        begin
            @(posedge clk);
            addr <= a;
            rd_stb <= 1'b1;
            @(posedge clk);
            rd_stb <= 1'b0;
            #1 chk(rdata, exp);
        end
    endtask

    // in pulse mode with a nonzero code, a pulse must be held for at least the hold count to reach the output
    task try(input [1:0] code, input m, input [7:0] len, input e);
        integer base;
        begin
            wr(`OFS_TUNING_ONE, {3'h0, code, 27'h0000000});
            speed_pulse_mode <= m;
            repeat (4) @(posedge clk);
            base = hi_cnt;
            speed_pin <= 1'b1;
            repeat (len) @(posedge clk);
            speed_pin <= 1'b0;
            repeat (130) @(posedge clk);
            chk({31'h0, hi_cnt != base}, {31'h0, e});
        end
    endtask

    task print_verdict;
        begin
            $display("compared %0d, failures %0d", n_compared, failures);
            if (failures == 0 && n_compared > 0)
                $display("Run complete: PASS");
            else
                $display("Run complete: FAIL");
            $finish;
        end
    endtask
////////////////////////////////////////////////////////////
    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        rd_chk(`OFS_TUNING_ONE, 32'h00000000);
        rd_chk(`OFS_TUNING_TWO, 32'h00000000);
        wr(`OFS_TUNING_ONE, 32'hffffffff);
        wr(`OFS_TUNING_TWO, 32'hffffffff);
        rd_chk(8'ha1, 32'h00000000);
        rd_chk(8'ha6, 32'h00000000);
        rd_chk(`OFS_TUNING_ONE, 32'h7ffe07ff);
        rd_chk(`OFS_TUNING_TWO, 32'h7ffffc00);
        rd_chk(8'ha4, 32'h00000000);
        for (i = 0; i < 8; i = i + 1) begin
            c = i[2:0];
            d1 = {1'b0, c[1:0], c[1:0], c[0], c[1:0], c[1:0], c[1:0], c,
                6'h00, c, c[1:0], c, c};
            d2 = {1'b0, c[1:0], c, 5'h1f, ~c[1:0], 5'h15, c, c[0], 10'h000};
            wr(`OFS_TUNING_ONE, d1 | 32'h8001f800);
            wr(`OFS_TUNING_TWO, d2 | 32'h800003ff);
            rd_chk(`OFS_TUNING_ONE, d1);
            rd_chk(`OFS_TUNING_TWO, d2);
            chk({31'h0, field_weaken_enable}, {31'h0, c[0]});
        end
        @(posedge clk);
        rst <= 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        rd_chk(`OFS_TUNING_ONE, 32'h00000000);
        rd_chk(`OFS_TUNING_TWO, 32'h00000000);
        try(2'h1, 1'b1, 8'h0a, 1'b0);
        try(2'h1, 1'b1, 8'h28, 1'b1);
        try(2'h2, 1'b1, 8'h28, 1'b0);
        try(2'h2, 1'b1, 8'h50, 1'b1);
        try(2'h3, 1'b1, 8'h5a, 1'b0);
        try(2'h3, 1'b1, 8'h82, 1'b1);
        try(2'h3, 1'b0, 8'h04, 1'b1);
        try(2'h0, 1'b1, 8'h04, 1'b1);
        print_verdict;
    end

    // whole run is under 3000 cycles
    initial begin
        #100000;
        failures = failures + 1;
        print_verdict;
    end
endmodule
